// ===== inc/mrs_pkg.sv
// Constants, types and helpers shared by the Modbus RTU slave engine
// How it works
// [RULE1] Serial characters are 8 data bits, no parity, one stop bit, nothing else.
// [RULE2] Baud selector holds codes 3 to 10 for 1200 up to 115200 bit/s.
// [RULE3] Function codes 01 to 06, 0F, 10 and vendor code 46 are serviced.
// [RULE4] Refused requests answer own address, function code with 0x80 set, exception code.
// [RULE5] Exception codes: 01 function, 02 address, 03 value, 04 host timeout.
// [RULE6] Frames whose CRC does not match are dropped without any reply; the code drops them only while the CRC-check coil is on.
// [RULE7] CRC-check coil: FF00 enables, 0000 disables; disabled after factory default.
// [RULE8] Slave address holds 1 to 247; only frames with matching address are answered.
// [RULE9] Coils use 01/05/0F, inputs 02, input registers 04, holding registers 03/06/10.
// [RULE10] The address carried in a request is the element number minus one.
// [RULE11] Inputs and input registers are read only; coils and holding registers read-write; the code leaves firmware, name and reset-status read only.
// [RULE12] Protocol coil: FF00 selects RTU, 0000 selects the ASCII command protocol.
// [RULE13] Writing FF00 to the factory coil reloads all parameters with defaults.
// [RULE14] Writing FF00 to the reboot coil restarts the module as at power-on; the code clears coils and sets the reset-status bit, keeping configuration.
// [RULE15] Reset-status bit reads 1 on the first read after power-up, then 0.
// [RULE16] Firmware version and module name are read-only 32-bit register pairs.
// [RULE17] Indicator bit 1 selects output LED lit or dark while output active.
// [RULE18] Indicator bit 0 selects input LED lit or dark while input active.
// [RULE19] Active-level bit 0 sets active input polarity; an open input is inactive.
// [RULE20] Active-level bit 1 sets the value driven for an active output.
// [RULE21] A line silence of 3.5 character times ends a request frame.
package mrs_pkg;
	localparam int          CLK_HZ      = 10_000_000;
	localparam int          NCH         = 8;
	localparam int          CH_W        = $clog2(NCH);
	localparam int          RX_DEPTH    = 48;
	localparam int          BAUD_TAB [3:10] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600,
		115200};
	localparam logic [15:0] MAX_BITS    = 16'h0040;
	localparam logic [15:0] MAX_REGS    = 16'h0010;
	localparam logic [18:0] GAP_BITS    = 19'h00023; // 3.5 characters of 10 bits each
	localparam logic [15:0] CRC_INIT    = 16'hFFFF;
	localparam logic [15:0] CRC_POLY    = 16'hA001;
	localparam logic [7:0]  FC_RD_COIL  = 8'h01;
	localparam logic [7:0]  FC_RD_DI    = 8'h02;
	localparam logic [7:0]  FC_RD_HR    = 8'h03;
	localparam logic [7:0]  FC_RD_IR    = 8'h04;
	localparam logic [7:0]  FC_WR_COIL  = 8'h05;
	localparam logic [7:0]  FC_WR_HR    = 8'h06;
	localparam logic [7:0]  FC_WR_COILS = 8'h0F;
	localparam logic [7:0]  FC_WR_HRS   = 8'h10;
	localparam logic [7:0]  FC_VENDOR   = 8'h46;
	localparam logic [7:0]  SUB_NAME    = 8'h00;
	localparam logic [7:0]  EXC_FLAG    = 8'h80;
	localparam logic [7:0]  EX_FUNC     = 8'h01;
	localparam logic [7:0]  EX_ADDR     = 8'h02;
	localparam logic [7:0]  EX_VAL      = 8'h03;
	localparam logic [7:0]  EX_HOST_TMO = 8'h04;
	localparam logic [15:0] COIL_ON     = 16'hFF00;
	localparam logic [15:0] COIL_OFF    = 16'h0000;
	localparam logic [15:0] HR_BASE     = 16'h9C40;
	localparam logic [15:0] A_PROTO     = 16'h0101 - 16'h0001;
	localparam logic [15:0] A_FACT      = 16'h0110 - 16'h0001;
	localparam logic [15:0] A_RSTF      = 16'h0111 - 16'h0001;
	localparam logic [15:0] A_CRC       = 16'h08A0 - 16'h0001;
	localparam logic [15:0] A_REBOOT    = 16'h08A2 - 16'h0001;
	localparam logic [15:0] A_FW        = 16'h9E21 - HR_BASE - 16'h0001;
	localparam logic [15:0] A_NAME      = 16'h9E23 - HR_BASE - 16'h0001;
	localparam logic [15:0] A_ADDR      = 16'h9E25 - HR_BASE - 16'h0001;
	localparam logic [15:0] A_BAUD      = 16'h9E26 - HR_BASE - 16'h0001;
	localparam logic [15:0] A_LED       = 16'hA4D9 - HR_BASE - 16'h0001;
	localparam logic [15:0] A_LVL       = 16'hA4E1 - HR_BASE - 16'h0001;
	localparam logic [7:0]  ADDR_MIN    = 8'h01;
	localparam logic [7:0]  ADDR_MAX    = 8'hF7;
	localparam logic [3:0]  BAUD_MIN    = 4'h3;
	localparam logic [3:0]  BAUD_MAX    = 4'hA;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_CHK  = 3'h1,
		S_WR   = 3'h2,
		S_TX   = 3'h3
	} mrs_state_e;

	typedef struct packed {
		logic       rtu;
		logic       crc_en;
		logic [7:0] addr;
		logic [3:0] baud;
		logic [1:0] led;
		logic [1:0] lvl;
	} mrs_cfg_s;

	localparam mrs_cfg_s CFG_DEF = '{rtu: 1'h1, crc_en: 1'h0, addr: 8'h01, baud: 4'h6,
		led: 2'h3, lvl: 2'h3};

	typedef struct packed {
		mrs_state_e                 st;
		logic [13:0]                rx_cnt;
		logic [3:0]                 rx_bit;
		logic                       rx_busy;
		logic [7:0]                 rx_sh;
		logic [18:0]                gap;
		logic [RX_DEPTH-1:0][7:0]   rbuf;
		logic [5:0]                 rx_len;
		logic                       rx_ovf;
		logic [15:0]                rx_crc;
		logic [13:0]                tx_cnt;
		logic [3:0]                 tx_bit;
		logic                       tx_busy;
		logic [8:0]                 tx_sh;
		logic [7:0]                 tx_idx;
		logic [15:0]                tx_crc;
		logic [7:0]                 idx;
		logic [7:0]                 exc;
		logic                       rd_rst;
		logic                       reboot;
		mrs_cfg_s                   cfg;
		logic [3:0]                 baud_live;
		logic                       rst_flag;
		logic [NCH-1:0]             coil;
		logic                       txd;
		logic [NCH-1:0]             dout_pin;
		logic [NCH-1:0]             dout_led;
		logic [NCH-1:0]             din_led;
	} mrs_state_s;

	function automatic logic [13:0] baud_div(input int clk_hz, input logic [3:0] code);
		logic [3:0] c;
		c = (code < BAUD_MIN || code > BAUD_MAX) ? CFG_DEF.baud : code;
		return 14'(clk_hz / BAUD_TAB[c]);
	endfunction

	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		return r;
	endfunction
endpackage

// ===== hdl/mrs_slave.sv
// Modbus RTU slave engine: serial framing, request decode, register map and reply
`timescale 1ns/10ps
`default_nettype none
module mrs_slave #(
	parameter int          CLK_HZ      = mrs_pkg::CLK_HZ, // Bit-timing reference
	parameter logic [31:0] FW_VERSION  = 32'h0001_0000, // Arbitrary value
	parameter logic [31:0] MODULE_NAME = 32'h0000_5A5A  // Arbitrary value
) (
	input  wire logic                    mclk_i,
	input  wire logic                    rst_i,
	input  wire logic                    rxd_i,
	input  wire logic [mrs_pkg::NCH-1:0] din_i,
	input  wire logic [mrs_pkg::NCH-1:0] din_open_i,
	output logic                         txd_o,
	output logic [mrs_pkg::NCH-1:0]      dout_o,
	output logic [mrs_pkg::NCH-1:0]      dout_led_o,
	output logic [mrs_pkg::NCH-1:0]      din_led_o,
	output logic                         rtu_sel_o
);
	mrs_pkg::mrs_state_s q;
	mrs_pkg::mrs_state_s d;

	logic [7:0]              fc;
	logic [15:0]             start;
	logic [15:0]             qty;
	logic [15:0]             elem;
	logic [5:0]              wi;
	logic [15:0]             wval;
	logic [mrs_pkg::NCH-1:0] act_in;
	logic                    is_bits;
	logic                    is_regs;
	logic [15:0]             exp_len;
	logic [7:0]              rlen;
	logic [7:0]              tx_byte;
	logic [13:0]             div;
	logic [18:0]             gap_lim;
	logic                    fend;

	assign fc    = q.rbuf[1];
	assign start = {q.rbuf[2], q.rbuf[3]};
	assign qty   = (fc == mrs_pkg::FC_WR_COIL || fc == mrs_pkg::FC_WR_HR) ? 16'h0001
		: {q.rbuf[4], q.rbuf[5]};
	assign elem  = start + {8'h00, q.idx};
	assign wi    = (fc == mrs_pkg::FC_WR_HRS) ? 6'(7 + 2 * int'(q.idx)) : 6'(7 + int'(q.idx[7:3]));
	assign wval  = (fc == mrs_pkg::FC_WR_COIL || fc == mrs_pkg::FC_WR_HR)
		? {q.rbuf[4], q.rbuf[5]}
		: (fc == mrs_pkg::FC_WR_COILS)
		? (q.rbuf[wi][q.idx[2:0]] ? mrs_pkg::COIL_ON : mrs_pkg::COIL_OFF)
		: {q.rbuf[wi], q.rbuf[6'(wi + 6'h01)]};
	// An open input never counts as active, whatever the polarity
	assign act_in = ~din_open_i & ~(din_i ^ {mrs_pkg::NCH{q.cfg.lvl[0]}}); // [RULE19]
	assign is_bits = fc == mrs_pkg::FC_RD_COIL || fc == mrs_pkg::FC_RD_DI
		|| fc == mrs_pkg::FC_WR_COILS;
	assign is_regs = fc == mrs_pkg::FC_RD_HR || fc == mrs_pkg::FC_RD_IR
		|| fc == mrs_pkg::FC_WR_HRS;
	assign exp_len = (fc == mrs_pkg::FC_WR_COILS) ? 16'h0009 + ((qty + 16'h0007) >> 3)
		: (fc == mrs_pkg::FC_WR_HRS) ? 16'h0009 + (qty << 1)
		: (fc == mrs_pkg::FC_VENDOR) ? 16'h0005 : 16'h0008;
	// Reply length without the two CRC bytes
	assign rlen = (q.exc != 8'h00) ? 8'h03
		: (fc == mrs_pkg::FC_RD_COIL || fc == mrs_pkg::FC_RD_DI)
		? 8'(16'h0003 + ((qty + 16'h0007) >> 3))
		: (fc == mrs_pkg::FC_RD_HR || fc == mrs_pkg::FC_RD_IR) ? 8'(16'h0003 + (qty << 1))
		: (fc == mrs_pkg::FC_VENDOR) ? 8'h07 : 8'h06;
	assign div     = mrs_pkg::baud_div(CLK_HZ, q.baud_live);
	assign gap_lim = 19'(mrs_pkg::GAP_BITS * {5'h00, div}); // [RULE21]
	assign fend    = q.gap == gap_lim && (q.rx_len != 6'h00 || q.rx_ovf); // [RULE21]

	function automatic logic elem_valid(input logic [7:0] f, input logic [15:0] e);
		case (f)
			mrs_pkg::FC_RD_COIL:
				return e < 16'(mrs_pkg::NCH) || e == mrs_pkg::A_PROTO || e == mrs_pkg::A_RSTF
					|| e == mrs_pkg::A_CRC;
			mrs_pkg::FC_WR_COIL, mrs_pkg::FC_WR_COILS:
				return e < 16'(mrs_pkg::NCH) || e == mrs_pkg::A_PROTO || e == mrs_pkg::A_FACT
					|| e == mrs_pkg::A_CRC || e == mrs_pkg::A_REBOOT;
			mrs_pkg::FC_RD_DI:
				return e < 16'(mrs_pkg::NCH);
			mrs_pkg::FC_RD_IR:
				return e == 16'h0000;
			mrs_pkg::FC_RD_HR:
				return (e >= mrs_pkg::A_FW && e <= mrs_pkg::A_BAUD) || e == mrs_pkg::A_LED
					|| e == mrs_pkg::A_LVL;
			mrs_pkg::FC_WR_HR, mrs_pkg::FC_WR_HRS:
				return e == mrs_pkg::A_ADDR || e == mrs_pkg::A_BAUD || e == mrs_pkg::A_LED
					|| e == mrs_pkg::A_LVL; // [RULE11] [RULE16]
			default:
				return 1'h0;
		endcase
	endfunction

	function automatic logic val_ok(input logic [7:0] f, input logic [15:0] e,
		input logic [15:0] v);
		if (f == mrs_pkg::FC_WR_COIL)
			return v == mrs_pkg::COIL_ON || v == mrs_pkg::COIL_OFF;
		if (f == mrs_pkg::FC_WR_HR || f == mrs_pkg::FC_WR_HRS)
		begin
			if (e == mrs_pkg::A_ADDR)
				return v >= {8'h00, mrs_pkg::ADDR_MIN} && v <= {8'h00, mrs_pkg::ADDR_MAX}; // [RULE8]
			if (e == mrs_pkg::A_BAUD)
				return v >= {12'h000, mrs_pkg::BAUD_MIN} && v <= {12'h000, mrs_pkg::BAUD_MAX}; // [RULE2]
		end
		return 1'h1;
	endfunction

	function automatic logic bit_rd(input logic [7:0] f, input logic [15:0] e,
		input mrs_pkg::mrs_state_s s, input logic [mrs_pkg::NCH-1:0] ai);
		if (f == mrs_pkg::FC_RD_DI)
			return ai[e[mrs_pkg::CH_W-1:0]];
		if (e == mrs_pkg::A_PROTO)
			return s.cfg.rtu;
		if (e == mrs_pkg::A_RSTF)
			return s.rst_flag; // [RULE15]
		if (e == mrs_pkg::A_CRC)
			return s.cfg.crc_en;
		return s.coil[e[mrs_pkg::CH_W-1:0]];
	endfunction

	function automatic logic [15:0] reg_rd(input logic [7:0] f, input logic [15:0] e,
		input mrs_pkg::mrs_state_s s, input logic [mrs_pkg::NCH-1:0] ai);
		if (f == mrs_pkg::FC_RD_IR)
			return 16'(ai);
		case (e)
			mrs_pkg::A_FW:                 return FW_VERSION[31:16]; // [RULE16]
			mrs_pkg::A_FW + 16'h0001:      return FW_VERSION[15:0];
			mrs_pkg::A_NAME:               return MODULE_NAME[31:16];
			mrs_pkg::A_NAME + 16'h0001:    return MODULE_NAME[15:0];
			mrs_pkg::A_ADDR:               return {8'h00, s.cfg.addr};
			mrs_pkg::A_BAUD:               return {12'h000, s.cfg.baud};
			mrs_pkg::A_LED:                return {14'h0000, s.cfg.led};
			default:                       return {14'h0000, s.cfg.lvl};
		endcase
	endfunction

	// Reply byte at position tx_idx: address, function code and write echoes from the request buffer, read data from the register map
	always_comb
	begin
		logic [7:0]  k;
		logic [15:0] off;
		k   = q.tx_idx - 8'h03;
		off = 16'h0000;
		tx_byte = 8'h00;
		if (q.tx_idx == 8'h00)
			tx_byte = q.rbuf[0];
		else if (q.tx_idx == 8'h01)
			tx_byte = (q.exc != 8'h00) ? (fc | mrs_pkg::EXC_FLAG) : fc; // [RULE4]
		else if (q.exc != 8'h00)
			tx_byte = q.exc; // [RULE4] [RULE5]
		else if (fc == mrs_pkg::FC_VENDOR)
			tx_byte = (q.tx_idx == 8'h02) ? mrs_pkg::SUB_NAME : MODULE_NAME[8'(8'h06 - q.tx_idx)*8 +: 8];
		else if (!(fc == mrs_pkg::FC_RD_COIL || fc == mrs_pkg::FC_RD_DI || fc == mrs_pkg::FC_RD_HR
			|| fc == mrs_pkg::FC_RD_IR))
			tx_byte = q.rbuf[q.tx_idx[5:0]];
		else if (q.tx_idx == 8'h02)
			tx_byte = rlen - 8'h03;
		else if (fc == mrs_pkg::FC_RD_COIL || fc == mrs_pkg::FC_RD_DI)
		begin
			for (int j = 0; j < 8; j++)
			begin
				off = {5'h00, k, 3'(j)};
				tx_byte[j] = (off < qty) && bit_rd(fc, start + off, q, act_in);
			end
		end
		else
		begin
			off = reg_rd(fc, start + {9'h000, k[7:1]}, q, act_in);
			tx_byte = k[0] ? off[7:0] : off[15:8];
		end
	end

	always_comb
	begin
		logic [7:0] b;
		b = 8'h00;
		d = q;
		// Receiver: mid-bit sampling, 8N1 only
		if (!q.rx_busy)
		begin
			if (!rxd_i)
			begin
				d.rx_busy = 1'h1;
				d.rx_cnt  = div >> 1;
				d.rx_bit  = 4'h0;
			end
		end
		else if (q.rx_cnt != 14'h0000)
			d.rx_cnt = q.rx_cnt - 14'h0001;
		else
		begin
			d.rx_cnt = div - 14'h0001;
			d.rx_bit = q.rx_bit + 4'h1;
			if (q.rx_bit == 4'h0 && rxd_i)
				d.rx_busy = 1'h0;
			else if (q.rx_bit >= 4'h1 && q.rx_bit <= 4'h8)
				d.rx_sh = {rxd_i, q.rx_sh[7:1]}; // [RULE1]
			else if (q.rx_bit == 4'h9)
			begin
				d.rx_busy = 1'h0;
				// A bad stop bit or a byte arriving while busy spoils the whole frame
				if (!rxd_i || q.st != mrs_pkg::S_IDLE || q.rx_len == 6'(mrs_pkg::RX_DEPTH)) // [RULE1]
					d.rx_ovf = 1'h1;
				else
				begin
					d.rbuf[q.rx_len] = q.rx_sh;
					d.rx_len = q.rx_len + 6'h01;
					d.rx_crc = mrs_pkg::crc_upd(q.rx_crc, q.rx_sh);
				end
			end
		end
		if (q.rx_busy || !rxd_i)
			d.gap = 19'h00000;
		else if (q.gap != gap_lim)
			d.gap = q.gap + 19'h00001; // [RULE21]

		case (q.st)
			mrs_pkg::S_IDLE:
			begin
				if (fend)
				begin
					d.rx_len = 6'h00;
					d.rx_ovf = 1'h0;
					d.rx_crc = mrs_pkg::CRC_INIT;
					d.idx    = 8'h00;
					d.exc    = 8'h00;
					d.rd_rst = 1'h0;
					// CRC over the frame including its own CRC leaves zero when intact
					if (!q.rx_ovf && q.rx_len >= 6'h04 && q.cfg.rtu // [RULE12]
						&& q.rbuf[0] == q.cfg.addr // [RULE8]
						&& !(q.cfg.crc_en && q.rx_crc != 16'h0000)) // [RULE6] [RULE7]
					begin
						d.st = mrs_pkg::S_CHK;
						if (!(fc inside {mrs_pkg::FC_RD_COIL, mrs_pkg::FC_RD_DI, mrs_pkg::FC_RD_HR,
							mrs_pkg::FC_RD_IR, mrs_pkg::FC_WR_COIL, mrs_pkg::FC_WR_HR,
							mrs_pkg::FC_WR_COILS, mrs_pkg::FC_WR_HRS, mrs_pkg::FC_VENDOR})) // [RULE3]
							d.exc = mrs_pkg::EX_FUNC; // [RULE5]
						else if (fc == mrs_pkg::FC_VENDOR && q.rbuf[2] != mrs_pkg::SUB_NAME)
							d.exc = mrs_pkg::EX_FUNC;
						else if ((is_bits && (qty == 16'h0000 || qty > mrs_pkg::MAX_BITS))
							|| (is_regs && (qty == 16'h0000 || qty > mrs_pkg::MAX_REGS))
							|| exp_len != {10'h000, q.rx_len}
							|| ((fc == mrs_pkg::FC_WR_COILS || fc == mrs_pkg::FC_WR_HRS)
							&& {8'h00, q.rbuf[6]} != exp_len - 16'h0009))
							d.exc = mrs_pkg::EX_VAL;
					end
				end
			end
			mrs_pkg::S_CHK:
			begin
				d.idx = q.idx + 8'h01;
				if (q.exc != 8'h00 || fc == mrs_pkg::FC_VENDOR)
					d.st = mrs_pkg::S_TX;
				else if (!elem_valid(fc, elem)) // [RULE9] [RULE10] [RULE11]
				begin
					d.exc = mrs_pkg::EX_ADDR;
					d.st  = mrs_pkg::S_TX;
				end
				else if (!val_ok(fc, elem, wval))
				begin
					d.exc = mrs_pkg::EX_VAL;
					d.st  = mrs_pkg::S_TX;
				end
				else
				begin
					if (fc == mrs_pkg::FC_RD_COIL && elem == mrs_pkg::A_RSTF)
						d.rd_rst = 1'h1; // [RULE15]
					if ({8'h00, q.idx} == qty - 16'h0001)
					begin
						d.idx = 8'h00;
						d.st  = (fc inside {mrs_pkg::FC_WR_COIL, mrs_pkg::FC_WR_HR,
							mrs_pkg::FC_WR_COILS, mrs_pkg::FC_WR_HRS}) ? mrs_pkg::S_WR
							: mrs_pkg::S_TX;
					end
				end
			end
			mrs_pkg::S_WR:
			begin
				d.idx = q.idx + 8'h01;
				if (fc == mrs_pkg::FC_WR_COIL || fc == mrs_pkg::FC_WR_COILS)
				begin
					if (elem < 16'(mrs_pkg::NCH))
						d.coil[elem[mrs_pkg::CH_W-1:0]] = wval == mrs_pkg::COIL_ON; // [RULE11]
					else if (elem == mrs_pkg::A_PROTO)
						d.cfg.rtu = wval == mrs_pkg::COIL_ON; // [RULE12]
					else if (elem == mrs_pkg::A_CRC)
						d.cfg.crc_en = wval == mrs_pkg::COIL_ON; // [RULE7]
					else if (elem == mrs_pkg::A_FACT && wval == mrs_pkg::COIL_ON)
						d.cfg = mrs_pkg::CFG_DEF; // [RULE13] [RULE7]
					else if (elem == mrs_pkg::A_REBOOT && wval == mrs_pkg::COIL_ON)
						d.reboot = 1'h1; // [RULE14]
				end
				else if (elem == mrs_pkg::A_ADDR)
					d.cfg.addr = wval[7:0]; // [RULE8]
				else if (elem == mrs_pkg::A_BAUD)
					d.cfg.baud = wval[3:0]; // [RULE2]
				else if (elem == mrs_pkg::A_LED)
					d.cfg.led = wval[1:0];
				else
					d.cfg.lvl = wval[1:0];
				if ({8'h00, q.idx} == qty - 16'h0001)
					d.st = mrs_pkg::S_TX;
			end
			mrs_pkg::S_TX:
			begin
				if (!q.tx_busy)
				begin
					if (q.tx_idx == rlen + 8'h02)
					begin
						d.st     = mrs_pkg::S_IDLE;
						d.tx_idx = 8'h00;
						d.tx_crc = mrs_pkg::CRC_INIT;
						// Baud change waits until the reply has gone out at the old rate
						d.baud_live = q.cfg.baud; // [RULE2]
						if (q.rd_rst)
							d.rst_flag = 1'h0; // [RULE15]
						if (q.reboot)
						begin
							d.reboot   = 1'h0;
							d.coil     = '0; // [RULE14]
							d.rst_flag = 1'h1;
						end
					end
					else
					begin
						if (q.tx_idx < rlen)
						begin
							b = tx_byte;
							d.tx_crc = mrs_pkg::crc_upd(q.tx_crc, tx_byte);
						end
						else
							b = (q.tx_idx == rlen) ? q.tx_crc[7:0] : q.tx_crc[15:8];
						d.tx_idx  = q.tx_idx + 8'h01;
						d.tx_busy = 1'h1;
						d.tx_sh   = {1'h1, b};
						d.txd     = 1'h0;
						d.tx_cnt  = div - 14'h0001;
						d.tx_bit  = 4'h0;
					end
				end
			end
			default:
				d.st = mrs_pkg::S_IDLE;
		endcase

		// Transmitter: start, 8 data bits LSB first, one stop bit
		if (q.tx_busy)
		begin
			if (q.tx_cnt != 14'h0000)
				d.tx_cnt = q.tx_cnt - 14'h0001;
			else
			begin
				d.tx_cnt = div - 14'h0001;
				d.tx_bit = q.tx_bit + 4'h1;
				if (q.tx_bit == 4'h9)
					d.tx_busy = 1'h0;
				else
				begin
					d.txd   = q.tx_sh[0]; // [RULE1]
					d.tx_sh = {1'h1, q.tx_sh[8:1]};
				end
			end
		end

		d.din_led  = q.cfg.led[0] ? act_in : ~act_in; // [RULE18]
		d.dout_led = q.cfg.led[1] ? q.coil : ~q.coil; // [RULE17]
		d.dout_pin = q.cfg.lvl[1] ? q.coil : ~q.coil; // [RULE20]
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			q           <= '0;
			q.cfg       <= mrs_pkg::CFG_DEF;
			q.baud_live <= mrs_pkg::CFG_DEF.baud;
			q.rx_crc    <= mrs_pkg::CRC_INIT;
			q.tx_crc    <= mrs_pkg::CRC_INIT;
			q.txd       <= 1'h1;
			q.rst_flag  <= 1'h1;
		end
		else
			q <= d;
	end

	assign txd_o      = q.txd;
	assign dout_o     = q.dout_pin;
	assign dout_led_o = q.dout_led;
	assign din_led_o  = q.din_led;
	assign rtu_sel_o  = q.cfg.rtu;
endmodule
`default_nettype wire

// ===== bench/mrs_slave_props.sv
// Port-level checker for the Modbus RTU slave engine
`timescale 1ns/10ps
`default_nettype none
module mrs_slave_props (
	input wire logic       mclk_i,
	input wire logic       rst_i,
	input wire logic       rxd_i,
	input wire logic [7:0] din_i,
	input wire logic [7:0] din_open_i,
	input wire logic       txd_o,
	input wire logic [7:0] dout_o,
	input wire logic [7:0] dout_led_o,
	input wire logic [7:0] din_led_o,
	input wire logic       rtu_sel_o
);
	logic [16:0] quiet_q;
	logic [16:0] low_q;
	// Quiet time saturates so a long idle never wraps back under the gap limit
	always_ff @(posedge mclk_i)
	begin
		quiet_q <= (rst_i || !rxd_i) ? 17'h00000 : quiet_q + {16'h0000, quiet_q != 17'h1FFFF};
		low_q <= (rst_i || txd_o) ? 17'h00000 : low_q + 17'h00001;
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// Bit-time figures follow the bench's 500 kHz reference: 4 cycles at 115200, 52 at 9600
	AST_RST_LINE: assert property ($fell(rst_i) |-> txd_o && rtu_sel_o)
		else $error("line or protocol select wrong after reset");
	AST_RST_OUTS: assert property ($fell(rst_i) |-> dout_o == 8'h00 && dout_led_o == 8'h00)
		else $error("outputs not cleared after reset");
	AST_GAP_FIRST: assert property ($fell(txd_o) |-> quiet_q >= 17'h0008C)
		else $error("reply started before the frame gap");
	AST_LOW_MAX: assert property (low_q <= 17'h00208)
		else $error("transmit line low longer than a character");
	AST_LOW_MIN: assert property ($rose(txd_o) |-> low_q >= 17'h00004)
		else $error("transmit low pulse shorter than a bit");
	AST_DIN_DIFF: assert property (!$past(rst_i) && !$past(rst_i, 2)
		&& $past(!din_open_i[7] && !din_open_i[6] && din_i[7] != din_i[6])
		|-> din_led_o[7] != din_led_o[6])
		else $error("differing closed inputs show equal indicators");
	AST_DIN_OPEN: assert property (!$past(rst_i) && !$past(rst_i, 2)
		&& $past(din_open_i[1:0] == 2'h3) |-> din_led_o[0] == din_led_o[1])
		else $error("open inputs show differing indicators");
	AST_OUT_UNIFORM: assert property ((dout_o ^ dout_led_o) == 8'h00
		|| (dout_o ^ dout_led_o) == 8'hFF)
		else $error("output indicator polarity not uniform");
	cover property ($fell(txd_o) && quiet_q >= 17'h0071C);
	cover property ($fell(rtu_sel_o));
	cover property ($rose(dout_o[0]));
endmodule
`default_nettype wire

// ===== bench/mrs_master.sv
// Modbus RTU master model on the serial line
`timescale 1ns/10ps
`default_nettype none
module mrs_master (
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      line_o
);
	// 9600 bit/s against the bench's 500 kHz bit-timing reference
	int div = 52;
	initial line_o = 1'b1;
	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] r;
		r = 16'hFFFF;
		foreach (q[i])
		begin
			r ^= {8'h00, q[i]};
			for (int b = 0; b < 8; b++)
				r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
		end
		return r;
	endfunction
	// 8N1, LSB first, check value low byte first; bad flips a check bit
	task automatic send(input logic [7:0] q[$], input logic bad);
		logic [15:0] c;
		logic [9:0]  f;
		c = crc(q) ^ {15'h0000, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i])
		begin
			f = {1'b1, q[i], 1'b0};
			for (int b = 0; b < 10; b++)
			begin
				@(negedge clk_i);
				line_o = f[b];
				repeat (div - 1) @(negedge clk_i);
			end
		end
	endtask
	// Gives up after 60 quiet bit times, well past the frame gap plus decode time
	task automatic recv(output logic [7:0] q[$]);
		int         t;
		logic [7:0] v;
		q = {};
		forever
		begin
			t = 0;
			while (line_i && t < 60 * div)
			begin
				@(negedge clk_i);
				t++;
			end
			if (line_i)
				break;
			repeat (div + div / 2) @(negedge clk_i);
			for (int b = 0; b < 8; b++)
			begin
				v[b] = line_i;
				repeat (div) @(negedge clk_i);
			end
			q.push_back(v);
		end
	endtask
endmodule
`default_nettype wire

// ===== bench/test_modbus_rtu_slave_register_map.sv
// Self-checking bench for the Modbus RTU slave engine
`timescale 1ns/10ps
`default_nettype none
module test_modbus_rtu_slave_register_map;
	typedef struct {int rl; logic [79:0] rq; int el; logic [95:0] ex;} mrs_row_s;
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	logic       rxd;
	logic       txd;
	logic       rtu_sel;
	logic [7:0] din = 8'hA5;
	logic [7:0] din_open = 8'h0F;
	logic [7:0] dout;
	logic [7:0] dout_led;
	logic [7:0] din_led;
	int         error_cnt = 0;
	int         compares = 0;
	mrs_row_s   rows [20] = '{
		'{6, 80'h010601E5000A, 6, 96'h010601E5000A},
		'{6, 80'h010301E00004, 11, 96'h0103080001000000005A5A},
		'{6, 80'h010101100001, 4, 96'h01010101},
		'{6, 80'h010101100001, 4, 96'h01010100},
		'{6, 80'h010700000001, 3, 96'h018701},
		'{6, 80'h010400100001, 3, 96'h018402},
		'{6, 80'h010500001234, 3, 96'h018503},
		'{6, 80'h010601E400F8, 3, 96'h018603},
		'{6, 80'h010601E5000B, 3, 96'h018603},
		'{6, 80'h01050000FF00, 6, 96'h01050000FF00},
		'{6, 80'h010100000008, 4, 96'h01010101},
		'{8, 80'h010F0000000801FF, 6, 96'h010F00000008},
		'{6, 80'h010200000008, 4, 96'h010201A0},
		'{6, 80'h010400000001, 5, 96'h01040200A0},
		'{6, 80'h010608980000, 6, 96'h010608980000},
		'{6, 80'h010608A00000, 6, 96'h010608A00000},
		'{3, 80'h014600, 7, 96'h01460000005A5A},
		'{9, 80'h011001E00001020000, 3, 96'h019002},
		'{6, 80'h020301E40001, 0, 96'h0},
		'{6, 80'h0105089FFF00, 6, 96'h0105089FFF00}};
	always #50 mclk = ~mclk;
	mrs_master m (.clk_i(mclk), .line_i(txd), .line_o(rxd));
	// Bit-timing reference scaled down so the whole run stays short
	mrs_slave #(.CLK_HZ(500_000), .FW_VERSION(32'h0001_0000), .MODULE_NAME(32'h0000_5A5A))
		dut (.mclk_i(mclk), .rst_i(rst), .rxd_i(rxd), .din_i(din), .din_open_i(din_open),
		.txd_o(txd), .dout_o(dout), .dout_led_o(dout_led), .din_led_o(din_led),
		.rtu_sel_o(rtu_sel));
	task automatic finish_test;
		if (error_cnt == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [95:0] got, input logic [95:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic xact(input mrs_row_s r, input logic bad);
		logic [7:0] q[$];
		logic [7:0] e[$];
		logic [7:0] a[$];
		logic [15:0] c;
		for (int i = r.rl - 1; i >= 0; i--)
			q.push_back(r.rq[8 * i +: 8]);
		for (int i = r.el - 1; i >= 0; i--)
			e.push_back(r.ex[8 * i +: 8]);
		c = m.crc(e);
		if (r.el > 0)
			e = {e, c[7:0], c[15:8]};
		m.send(q, bad);
		m.recv(a);
		check(96'(a.size()), 96'(e.size()));
		if (a.size() == e.size())
			foreach (e[i])
				check(96'(a[i]), 96'(e[i]));
	endtask
	initial
	begin
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		foreach (rows[i])
		begin
			xact(rows[i], 1'b0);
			if (i == 0)
				m.div = 4;
		end
		check(96'({dout, dout_led, din_led}), 96'h0000AF);
		xact('{6, 80'h010301E40001, 0, 96'h0}, 1'b1);
		xact('{6, 80'h010301E40001, 5, 96'h0103020001}, 1'b0);
		xact('{6, 80'h010508A1FF00, 6, 96'h010508A1FF00}, 1'b0);
		repeat (4) @(negedge mclk);
		check(96'(dout), 96'h0FF);
		xact('{6, 80'h010101100001, 4, 96'h01010101}, 1'b0);
		xact('{6, 80'h0105010FFF00, 6, 96'h0105010FFF00}, 1'b0);
		// Factory settings bring back 9600 bit/s once the reply is out
		m.div = 52;
		check(96'({dout, dout_led, din_led}), 96'h0000A0);
		xact('{6, 80'h010501000000, 6, 96'h010501000000}, 1'b0);
		check(96'(rtu_sel), 96'h0);
		xact('{6, 80'h010301E40001, 0, 96'h0}, 1'b0);
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		@(negedge mclk);
		check(96'({rtu_sel, dout, dout_led}), 96'h10000);
		finish_test();
	end
	// Whole run is about 60 thousand cycles, mostly the frames at 9600
	initial
	begin
		repeat (80000) @(posedge mclk);
		error_cnt++;
		finish_test();
	end
endmodule
bind mrs_slave mrs_slave_props u_props (.mclk_i(mclk_i), .rst_i(rst_i), .rxd_i(rxd_i),
	.din_i(din_i), .din_open_i(din_open_i), .txd_o(txd_o), .dout_o(dout_o),
	.dout_led_o(dout_led_o), .din_led_o(din_led_o), .rtu_sel_o(rtu_sel_o));
`default_nettype wire
